// ==== rtl/cache_data_pkg.sv ====
// Constants shared by the cache data slice and its helper modules.
// Function
// - All bus signals except output enable are sampled and driven only on the module bus clock rising edge.
// - Storage array holds 4096 words of 32 bits.
// - The 14-bit word address is registered on the clock edge.
// - Store data is captured into input latches on the clock edge.
// - Both chip selects are registered with the address every edge.
// - Read flag is registered each cycle; high reads, low writes.
// - A processor write spans two read-low cycles, treated as one pipelined write.
// - Data bus driven only when read flag is 1 and output enable is 0.
// - Byte enable bit 0 gates bits 31:24, up to bit 3 gating bits 7:0.
// - Each write waits in a one-deep buffer until the next write commits it.
// - Reads matching the buffer address receive forwarded buffer data.
// - Four per-byte valid bits decide which buffered bytes reach the array.
// - One array access completes per clock; a new one may start every edge.
package cache_data_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int WORDS = 4096;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [LANES-1:0] BWE_N_RST = 4'hF;
  localparam logic [LANES-1:0] VALID_RST = 4'h0;
  localparam logic CE_N_RST = 1'h1;
  localparam logic CE_RST = 1'h0;
  localparam logic RD_RST = 1'h0;
endpackage

// ==== rtl/cache_word_array.sv ====
// Word-wide storage core with per-lane write strobes and an unregistered read port.
`timescale 1ns/1ps
module cache_word_array #(
  parameter int ADDR_W = cache_data_pkg::ADDR_W,
  parameter int WORDS  = cache_data_pkg::WORDS,
  parameter int LANES  = cache_data_pkg::LANES,
  parameter int LANE_W = cache_data_pkg::LANE_W
) (
  input  wire logic                      clk_in,
  input  wire logic                      write_in,
  input  wire logic [ADDR_W-1:0]         write_addr_in,
  input  wire logic [LANES-1:0]          write_lane_in,
  input  wire logic [LANES*LANE_W-1:0]   write_data_in,
  input  wire logic [ADDR_W-1:0]         read_addr_in,
  output logic      [LANES*LANE_W-1:0]   read_data_out
);
  localparam int IDX_W = $clog2(WORDS);

  // The core is deliberately unreset; software sees whatever the fills put there.
  logic [LANES*LANE_W-1:0] mem [WORDS];

  // Only the low address bits index the core, so the depth must be a power of
  // two that the address can reach; anything else is refused at build time.
  if (WORDS < 2 || WORDS > (1 << ADDR_W) || (1 << IDX_W) != WORDS) begin : g_bad_depth
    $error("cache_word_array: WORDS does not fit the address range.");
  end

  // Lane i of the strobe writes the lane that sits highest first, as the bus numbers it.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    localparam int HI = LANES*LANE_W - 1 - i*LANE_W;
    always_ff @(posedge clk_in) begin
      if (write_in && write_lane_in[i]) begin
        mem[write_addr_in[IDX_W-1:0]][HI -: LANE_W] <= write_data_in[HI -: LANE_W];
      end
    end
  end

  // Combinational read; the caller registers the word so the bus sees a flop.
  assign read_data_out = mem[read_addr_in[IDX_W-1:0]];
endmodule

// ==== rtl/byte_lane_merge.sv ====
// Per-lane selector that overlays valid buffered bytes on array bytes.
`timescale 1ns/1ps
module byte_lane_merge #(
  parameter int LANES  = cache_data_pkg::LANES,
  parameter int LANE_W = cache_data_pkg::LANE_W
) (
  input  wire logic                    hit_in,
  input  wire logic [LANES-1:0]        valid_in,
  input  wire logic [LANES*LANE_W-1:0] buffer_data_in,
  input  wire logic [LANES*LANE_W-1:0] array_data_in,
  output logic      [LANES*LANE_W-1:0] merged_out
);
  // Bit 0 of the valid vector belongs to the most significant lane.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    localparam int HI = LANES*LANE_W - 1 - i*LANE_W;
    assign merged_out[HI -: LANE_W] = (hit_in && valid_in[i]) ?
                                      buffer_data_in[HI -: LANE_W] :
                                      array_data_in[HI -: LANE_W];
  end
endmodule

// ==== rtl/cache_data_slice.sv ====
// Synchronous cache data slice with registered inputs, write buffer and forwarding.
`timescale 1ns/1ps
module cache_data_slice #(
  parameter int ADDR_W = cache_data_pkg::ADDR_W,
  parameter int WORDS  = cache_data_pkg::WORDS,
  parameter int LANES  = cache_data_pkg::LANES,
  parameter int LANE_W = cache_data_pkg::LANE_W
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic [ADDR_W-1:0]       module_word_address_in,
  input  wire logic [LANES*LANE_W-1:0] module_data_bus_in,
  output logic      [LANES*LANE_W-1:0] module_data_bus_out,
  output logic      [LANES*LANE_W-1:0] module_data_bus_oe_n_out,
  input  wire logic                    chip_enable_n_in,
  input  wire logic                    chip_enable_in,
  input  wire logic                    access_type_bits_in,
  input  wire logic                    ram_output_enable_n_in,
  input  wire logic [LANES-1:0]        byte_write_enable_n_in
);
  localparam int DATA_W = LANES * LANE_W;

  // The byte enables and reset constants are fixed at four lanes of a byte, so
  // any other layout is refused while the design is built.
  if (LANES != cache_data_pkg::LANES || LANE_W != cache_data_pkg::LANE_W) begin : g_bad_layout
    $error("cache_data_slice: lane layout must match the bus byte enables.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input registers. The masters drive everything unlatched, so all of it but the output enable is
  // caught here on the one clock; only the drive enable looks at the raw output enable pin.
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [LANES-1:0]  bwe_n_reg;
  logic              ce_n_reg;
  logic              ce_reg;
  logic              rd_reg;

  // Address capture. Every flop below loads on every edge, whether or not the
  // cycle is selected; decode happens one stage later.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_reg <= cache_data_pkg::ADDR_RST;
    end else begin
      addr_reg <= module_word_address_in;
    end
  end

  // Store data and byte enables enter the input latches together.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdata_reg <= cache_data_pkg::DATA_RST;
      bwe_n_reg <= cache_data_pkg::BWE_N_RST;
    end else begin
      wdata_reg <= module_data_bus_in;
      bwe_n_reg <= byte_write_enable_n_in;
    end
  end

  // Both chip selects ride with the address so bank decode stays aligned.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ce_n_reg <= cache_data_pkg::CE_N_RST;
      ce_reg   <= cache_data_pkg::CE_RST;
    end else begin
      ce_n_reg <= chip_enable_n_in;
      ce_reg   <= chip_enable_in;
    end
  end

  // The read flag only speaks for the address of its own cycle.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_reg <= cache_data_pkg::RD_RST;
    end else begin
      rd_reg <= access_type_bits_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode on the registered cycle.
  logic sel;
  logic rd_acc;
  logic wr_acc;

  // A write's first cycle carries no byte enables (the tag side is still
  // translating), so only the cycle with strobes loads the buffer. A read is
  // taken for its single cycle only.
  assign sel    = !ce_n_reg && ce_reg;
  assign rd_acc = sel && rd_reg;
  assign wr_acc = sel && !rd_reg && (bwe_n_reg != cache_data_pkg::BWE_N_RST);

  ////////////////////////////////////////////////////////////////////////////
  // One-deep write buffer.
  logic [ADDR_W-1:0] buf_addr_reg;
  logic [DATA_W-1:0] buf_data_reg;
  logic [LANES-1:0]  buf_valid_reg;

  // Each accepted write replaces the buffer; the old contents go to the core
  // in the same edge, which is the only moment the core is written.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      buf_addr_reg  <= cache_data_pkg::ADDR_RST;
      buf_data_reg  <= cache_data_pkg::DATA_RST;
      buf_valid_reg <= cache_data_pkg::VALID_RST;
    end else if (wr_acc) begin
      buf_addr_reg  <= addr_reg;
      buf_data_reg  <= wdata_reg;
      buf_valid_reg <= ~bwe_n_reg;
    end
  end

  logic commit;
  // The first write after reset finds the buffer empty and commits nothing.
  assign commit = wr_acc && (buf_valid_reg != cache_data_pkg::VALID_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Storage core and forwarding path.
  logic [DATA_W-1:0] array_rdata;
  logic [DATA_W-1:0] merged_rdata;
  logic              hit;

  cache_word_array #(
    .ADDR_W (ADDR_W),
    .WORDS  (WORDS),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_array (
    .clk_in        (clk_in),
    .write_in      (commit),
    .write_addr_in (buf_addr_reg),
    .write_lane_in (buf_valid_reg),
    .write_data_in (buf_data_reg),
    .read_addr_in  (addr_reg),
    .read_data_out (array_rdata)
  );

  // The core still holds stale bytes for a buffered word, hence the compare.
  // The whole word address is compared, so words that alias in the core never forward.
  assign hit = (buf_addr_reg == addr_reg) && (buf_valid_reg != cache_data_pkg::VALID_RST);

  byte_lane_merge #(
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_merge (
    .hit_in         (hit),
    .valid_in       (buf_valid_reg),
    .buffer_data_in (buf_data_reg),
    .array_data_in  (array_rdata),
    .merged_out     (merged_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage. Read data is held in a flop for the data phase, one cycle
  // after the registered read; the core finishes within that period.
  logic [DATA_W-1:0] rdata_reg;
  logic              rd_phase_reg;

  // Capture the merged word for each accepted read. Between reads the flop holds,
  // so a late output enable still sees the last word.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= cache_data_pkg::DATA_RST;
    end else if (rd_acc) begin
      rdata_reg <= merged_rdata;
    end
  end

  // The drive window follows the registered read flag of a selected cycle.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_phase_reg <= 1'h0;
    end else begin
      rd_phase_reg <= rd_acc;
    end
  end

  // Output enable is low while driving; a write or a deselected cycle never drives.
  assign module_data_bus_out      = rdata_reg;
  assign module_data_bus_oe_n_out = {DATA_W{!(rd_phase_reg && !ram_output_enable_n_in)}};

  ////////////////////////////////////////////////////////////////////////////
  // Checks kept beside the logic they guard. Some are phrased from the pins or
  // the registered cycle; others lean on the decoded wr_acc, rd_acc, hit and commit.

  sequence s_write_setup;
    sel && !rd_reg && (bwe_n_reg == cache_data_pkg::BWE_N_RST);
  endsequence

  sequence s_write_data;
    sel && !rd_reg && (bwe_n_reg != cache_data_pkg::BWE_N_RST);
  endsequence

  sequence s_read_taken;
    sel && rd_reg;
  endsequence

  // Judged only from an edge that saw reset high; the releasing edge still loads zero.
  property p_addr_pipe;
    @(posedge clk_in) disable iff (!rst_b_in)
      rst_b_in |=> addr_reg == $past(module_word_address_in);
  endproperty
  AST_ADDR_CAPTURED: assert property (p_addr_pipe)
    else $error("Word address not registered on the edge.");

  AST_DATA_LATCHED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_write_data |=> buf_data_reg == $past(module_data_bus_in, 2))
    else $error("Buffered store data differs from the bus two edges back.");

  AST_DRIVE_CAUSE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !module_data_bus_oe_n_out[0] |-> $past(access_type_bits_in, 2)
      && !$past(chip_enable_n_in, 2) && $past(chip_enable_in, 2) && !ram_output_enable_n_in)
    else $error("Data bus driven without a selected read two edges earlier.");

  AST_DESELECT_QUIET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !sel |-> !wr_acc && !rd_acc ##1 module_data_bus_oe_n_out[0])
    else $error("Deselected cycle was taken or drove the bus.");

  AST_PIPELINED_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_write_setup ##1 s_write_data |=> buf_addr_reg == $past(addr_reg)
      && buf_valid_reg == ~$past(bwe_n_reg))
    else $error("Two-cycle write did not load the buffer once.");

  AST_SETUP_NO_LOAD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_write_setup |=> $stable(buf_valid_reg) && $stable(buf_addr_reg))
    else $error("Write setup cycle disturbed the buffer.");

  AST_COMMIT_ON_NEXT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_write_data ##1 !wr_acc ##1 s_write_data |-> commit
      && u_array.write_addr_in == $past(addr_reg, 2))
    else $error("Buffered write not committed when the next write came.");

  AST_NO_EARLY_COMMIT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    u_array.write_in |-> !$past(access_type_bits_in) && !$past(chip_enable_n_in)
      && $past(chip_enable_in) && ($past(byte_write_enable_n_in) != cache_data_pkg::BWE_N_RST))
    else $error("Core written without a new write arriving.");

  AST_LANE_STROBES: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_write_data ##1 !wr_acc ##1 s_write_data
      |-> u_array.write_lane_in == ~$past(bwe_n_reg, 2))
    else $error("Committed lanes differ from the stored valid bits.");

  AST_FORWARD_FULL: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_read_taken and (hit && buf_valid_reg == 4'hF) |=> rdata_reg == $past(buf_data_reg))
    else $error("Fully buffered word not forwarded on a read.");

  AST_FORWARD_LANE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_read_taken and hit and buf_valid_reg[0] |=> rdata_reg[31:24] == $past(buf_data_reg[31:24]))
    else $error("Valid top lane not merged from the buffer.");

  AST_READ_EACH_CYCLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_read_taken ##1 s_read_taken |-> rd_phase_reg ##1 rd_phase_reg)
    else $error("Back-to-back reads did not each get a data phase.");

  AST_LANE_ZERO_HIGH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_write_data and bwe_n_reg == 4'hE |=> buf_valid_reg == 4'h1)
    else $error("Enable bit 0 did not mark the top lane valid.");

  AST_READ_NOT_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rd_reg |-> !wr_acc ##1 ($stable(buf_data_reg) && $stable(buf_valid_reg)))
    else $error("A read cycle altered the write buffer.");

  // The selects and the read flag are single flops off the pins; a flag that
  // arrived a cycle late would pair with the wrong address.
  AST_SELECTS_CAPTURED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rst_b_in |=> ce_n_reg == $past(chip_enable_n_in) && ce_reg == $past(chip_enable_in))
    else $error("Chip selects not registered on the edge.");

  AST_FLAG_CAPTURED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rst_b_in |=> rd_reg == $past(access_type_bits_in))
    else $error("Read flag not registered on the edge.");

  // All data lines share one enable; a split enable would fight the masters.
  AST_DRIVE_WHOLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    module_data_bus_oe_n_out == {DATA_W{module_data_bus_oe_n_out[0]}})
    else $error("Data lines enabled unevenly.");

  AST_READ_DRIVES: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_read_taken ##1 !ram_output_enable_n_in |-> module_data_bus_oe_n_out == '0)
    else $error("Selected read with output enable low did not drive.");

  AST_OE_RELEASES: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ram_output_enable_n_in |-> &module_data_bus_oe_n_out)
    else $error("Data bus driven with output enable high.");

  AST_WRITE_QUIET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_write_data |=> &module_data_bus_oe_n_out)
    else $error("Write cycle drove the data bus.");

  // The read word must stand unchanged until the next read replaces it.
  AST_DATA_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !rd_acc |=> $stable(module_data_bus_out))
    else $error("Read data changed without a read.");

  // A read that misses the buffer must take every byte from the core.
  AST_MISS_FROM_CORE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_read_taken and !hit |=> rdata_reg == $past(array_rdata))
    else $error("Read without a buffer match took buffered bytes.");

  // An empty buffer has nothing to commit, whatever the bus does.
  AST_EMPTY_NO_COMMIT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    buf_valid_reg == cache_data_pkg::VALID_RST |-> !u_array.write_in)
    else $error("Core written from an empty buffer.");
endmodule

// ==== bench/bus_master_model.sv ====
// Model of the processor and tag controller that drive the slice's module bus.
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] bus_out_in,
  input  wire logic [31:0] bus_oe_n_in,
  output logic      [13:0] addr_out,
  output logic      [31:0] bus_wire_out,
  output logic             ce_n_out,
  output logic             ce_out,
  output logic             rd_out,
  output logic             oe_n_out,
  output logic      [3:0]  bwe_n_out
);
  logic [31:0] store_data;
  logic        store_drive;
  logic [31:0] float_bits;

  // Idle bus: both selects off, no store data driven.
  initial begin
    addr_out = 14'h0000;
    ce_n_out = 1'b1;
    ce_out = 1'b0;
    rd_out = 1'b0;
    oe_n_out = 1'b0;
    bwe_n_out = 4'hF;
    store_data = 32'h0000_0000;
    store_drive = 1'b0;
    float_bits = 32'h5A5A_A5A5;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Released lines toggle every cycle, so a stale value can never pass for data.
  always @(posedge clk_in) float_bits <= ~float_bits;

  // Wire level worked out from both parties; the slice wins where it drives.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      bus_wire_out[i] = !bus_oe_n_in[i] ? bus_out_in[i] :
                        (store_drive ? store_data[i] : float_bits[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The sel pair is {active-low select, active-high select}, as address bit 17 feeds them.
  task automatic idle();
    @(posedge clk_in);
    ce_n_out <= 1'b1;
    ce_out <= 1'b0;
    rd_out <= 1'b0;
    bwe_n_out <= 4'hF;
    store_drive <= 1'b0;
  endtask

  // A read stays on the bus for one cycle only; the caller moves on at the next edge.
  task automatic read_cycle(input logic [13:0] a, input logic [1:0] sel);
    @(posedge clk_in);
    addr_out <= a;
    {ce_n_out, ce_out} <= sel;
    rd_out <= 1'b1;
    bwe_n_out <= 4'hF;
    store_drive <= 1'b0;
  endtask

  // Processor store: setup cycle with enables high, then data cycle; flag low in both.
  task automatic write_cycles(input logic [13:0] a, input logic [31:0] d,
                              input logic [3:0] ben_n, input logic [1:0] sel);
    @(posedge clk_in);
    addr_out <= a;
    {ce_n_out, ce_out} <= sel;
    rd_out <= 1'b0;
    bwe_n_out <= 4'hF;
    store_drive <= 1'b0;
    @(posedge clk_in);
    bwe_n_out <= ben_n;
    store_data <= d;
    store_drive <= 1'b1;
  endtask

  task automatic set_oe(input logic v);
    oe_n_out <= v;
  endtask
endmodule

// ==== bench/cache_data_slice_tb.sv ====
// Self-checking testbench for the cache data slice.
`timescale 1ns/1ps
module cache_data_slice_tb;
  logic        clk_in;
  logic        rst_b_in;
  logic [13:0] addr;
  logic [31:0] wire_d;
  logic [31:0] dout;
  logic [31:0] oe_n;
  logic        ce_n;
  logic        ce;
  logic        rd;
  logic        oe_pin_n;
  logic [3:0]  bwe_n;
  int          n_fail;
  int          tests_run;
  int          cycles = 0;

  cache_data_slice dut_u (
    .clk_in                   (clk_in),
    .rst_b_in                 (rst_b_in),
    .module_word_address_in   (addr),
    .module_data_bus_in       (wire_d),
    .module_data_bus_out      (dout),
    .module_data_bus_oe_n_out (oe_n),
    .chip_enable_n_in         (ce_n),
    .chip_enable_in           (ce),
    .access_type_bits_in      (rd),
    .ram_output_enable_n_in   (oe_pin_n),
    .byte_write_enable_n_in   (bwe_n)
  );

  bus_master_model pm_u (
    .clk_in       (clk_in),
    .bus_out_in   (dout),
    .bus_oe_n_in  (oe_n),
    .addr_out     (addr),
    .bus_wire_out (wire_d),
    .ce_n_out     (ce_n),
    .ce_out       (ce),
    .rd_out       (rd),
    .oe_n_out     (oe_pin_n),
    .bwe_n_out    (bwe_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  // Hang guard: the whole run needs little more than a hundred cycles.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic compare_word(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t data exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic compare_oe(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t drive enable exp %h got %h", $time, exp, got);
    end
  endtask

  // Selected read; data phase is the cycle after the registered read, then release.
  task automatic check_read(input logic [13:0] a, input logic [31:0] exp);
    pm_u.read_cycle(a, 2'b01);
    pm_u.idle();
    @(posedge clk_in);
    @(negedge clk_in);
    compare_oe(32'h0000_0000, oe_n);
    compare_word(exp, dout);
    @(negedge clk_in);
    compare_oe(32'hFFFF_FFFF, oe_n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Each lane alone over a committed zero word: only that byte comes from the buffer.
  task automatic test_lanes();
    for (int i = 0; i < 4; i++) begin
      pm_u.write_cycles(14'h0040, 32'h0000_0000, 4'h0, 2'b01);
      pm_u.write_cycles(14'h0040, 32'hFFFF_FFFF, ~(4'h1 << i), 2'b01);
      check_read(14'h0040, 32'hFF00_0000 >> (8 * i));
    end
    $display("test lanes done");
  endtask

  // Commit happens only when the next write arrives; the newest stays forwarded.
  task automatic test_commit();
    pm_u.write_cycles(14'h0050, 32'h1234_5678, 4'h0, 2'b01);
    @(negedge clk_in);
    compare_oe(32'hFFFF_FFFF, oe_n);
    pm_u.write_cycles(14'h0060, 32'h9ABC_DEF0, 4'h0, 2'b01);
    check_read(14'h0040, 32'h0000_00FF);
    check_read(14'h0050, 32'h1234_5678);
    check_read(14'h0060, 32'h9ABC_DEF0);
    $display("test commit done");
  endtask

  // Every deselecting select pair is ignored, for writes and for reads.
  task automatic test_select();
    for (int s = 0; s < 4; s++) begin
      if (s != 1) begin
        pm_u.write_cycles(14'h0050, 32'hDEAD_BEEF, 4'h0, 2'(s));
        pm_u.read_cycle(14'h0050, 2'(s));
        pm_u.idle();
        @(posedge clk_in);
        @(negedge clk_in);
        compare_oe(32'hFFFF_FFFF, oe_n);
      end
    end
    check_read(14'h0050, 32'h1234_5678);
    check_read(14'h0060, 32'h9ABC_DEF0);
    $display("test select done");
  endtask

  // Output enable held high over the data phase keeps the bus released.
  task automatic test_oe();
    pm_u.read_cycle(14'h0050, 2'b01);
    pm_u.set_oe(1'b1);
    pm_u.idle();
    @(posedge clk_in);
    @(negedge clk_in);
    compare_oe(32'hFFFF_FFFF, oe_n);
    pm_u.idle();
    pm_u.set_oe(1'b0);
    $display("test oe done");
  endtask

  // Reads on consecutive edges answer on consecutive cycles.
  task automatic test_back_to_back();
    pm_u.read_cycle(14'h0050, 2'b01);
    pm_u.read_cycle(14'h0060, 2'b01);
    pm_u.idle();
    @(negedge clk_in);
    compare_word(32'h1234_5678, dout);
    @(negedge clk_in);
    compare_word(32'h9ABC_DEF0, dout);
    $display("test back to back done");
  endtask

  // A reset in mid-run empties the buffer: the parked word is lost, never committed.
  task automatic test_reset_mid();
    pm_u.write_cycles(14'h0070, 32'h0F0F_0F0F, 4'h0, 2'b01);
    pm_u.write_cycles(14'h0060, 32'h1111_1111, 4'h0, 2'b01);
    check_read(14'h0060, 32'h1111_1111);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    compare_oe(32'hFFFF_FFFF, oe_n);
    compare_word(32'h0000_0000, dout);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    pm_u.write_cycles(14'h0080, 32'h2222_2222, 4'h0, 2'b01);
    pm_u.write_cycles(14'h0090, 32'h3333_3333, 4'h0, 2'b01);
    check_read(14'h0060, 32'h9ABC_DEF0);
    check_read(14'h0070, 32'h0F0F_0F0F);
    check_read(14'h0080, 32'h2222_2222);
    $display("test reset mid done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset for three cycles, checked released while held, then the scenarios.
  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_b_in = 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    compare_oe(32'hFFFF_FFFF, oe_n);
    compare_word(32'h0000_0000, dout);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    $display("test reset done");
    test_lanes();
    test_commit();
    test_select();
    test_oe();
    test_back_to_back();
    test_reset_mid();
    conclude();
  end
endmodule
